// [adcc_pkg.sv]
/*
  Shared constants and types of the converter control pair.
  Assumes one clock, mclk at 10 MHz, used as the converter clock.
*/
`default_nettype none
package adcc_pkg;
  // ****************************************
  // Conversion timing in converter cycles
  // ****************************************
  localparam int CYC_SH_8 = 28;
  localparam int CYC_SH_10 = 33;
  localparam int CYC_NOSH_8 = 49;
  localparam int CYC_NOSH_10 = 59;
  // ****************************************
  // Controller register offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_DMA = 8'h0C;
  localparam logic [7:0] OFS_TRIG = 8'h10;
  localparam logic [7:0] OFS_ANALOG = 8'h14;
  // ****************************************
  // Control, status and trigger register fields
  // ****************************************
  localparam int B_START = 0;
  localparam int B_TRG_TYPE = 1;
  localparam int B_TRG_SRC = 2;
  localparam int B_RES10 = 3;
  localparam int B_SMP = 4;
  localparam int B_DMA = 5;
  localparam int B_EXT = 6;
  localparam int B_REPEAT = 8;
  localparam int B_CHAN = 9;
  localparam int B_PGRP = 12;
  localparam int B_MSS = 14;
  localparam int B_DONE = 1;
  localparam int B_DMAV = 2;
  localparam int B_EXTPIN = 1;
  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [14:0] CTRL_RST = 15'h0000;
  localparam logic [1:0] EXT_NONE = 2'h0;
  localparam logic [1:0] EXT_FIRST = 2'h1;
  localparam logic [1:0] EXT_SECOND = 2'h2;
  localparam logic [1:0] EXT_OPAMP = 2'h3;
  localparam logic [3:0] SRC_EXT0 = 4'h8;
  localparam logic [3:0] SRC_EXT1 = 4'h9;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_CONV = 2'b01} adcc_state_t;
endpackage
`default_nettype wire

// [adcc_if.sv]
/*
  Link between converter control and its controller end.
  Assumes both ends run on the same mclk.
*/
`timescale 1ns/1ps
`default_nettype none
interface adcc_if;
  // Settings and triggers from the controller end
  logic start_bit;
  logic trig_type;
  logic trig_src;
  logic res_10;
  logic smp_en;
  logic dma_en;
  logic [1:0] ext_field;
  logic repeat_mode;
  logic [2:0] channel_sel;
  logic ext_trig_pin;
  logic timer_trig;
  logic [9:0] analog_code;
  logic [2:0] rd_index;
  // State and results from the converter
  logic busy;
  logic conv_done;
  logic dma_req;
  logic [15:0] first_result;
  logic [15:0] rd_data;
  logic [3:0] input_sel;
  logic ext0_out_en;
  logic ext0_in_en;
  logic ext1_in_en;
  modport dev (input start_bit, trig_type, trig_src, res_10, smp_en,
    dma_en, ext_field, repeat_mode, channel_sel, ext_trig_pin,
    timer_trig, analog_code, rd_index, output busy, conv_done, dma_req,
    first_result, rd_data, input_sel, ext0_out_en, ext0_in_en,
    ext1_in_en);
  modport ctl (output start_bit, trig_type, trig_src, res_10, smp_en,
    dma_en, ext_field, repeat_mode, channel_sel, ext_trig_pin,
    timer_trig, analog_code, rd_index, input busy, conv_done, dma_req,
    first_result, rd_data, input_sel, ext0_out_en, ext0_in_en,
    ext1_in_en);
endinterface
`default_nettype wire

// [adcc_device.sv]
/*
  Converter control: trigger selection, conversion timing, result
  placement, DMA funnelling and extended-input routing.
  Assumes analog_code already holds the code of the pin on input_sel.
*/
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - 10-bit result goes to bits 9..0
// - 8-bit result goes to bits 7..0
// - Sample-hold takes 28 or 33 cycles
// - Software fixes sample-hold before starting
// - Type 0 starts on start bit write
// - External falling edge starts when selected
// - Divided timer request starts when selected
// - Hardware triggers need start bit set
// - Retrigger aborts and restarts conversion
// - DMA mode funnels all into first register
// - DMA request after every pin conversion
// - Sweep modes require DMA mode enabled
// - DMA width follows resolution
// - No software read of first register in DMA mode
// - Decode the two-bit extended-input field
// - Extended results to first, second register
// - Extended inputs need group 00, no sweep
// - Op-amp mode outputs main channel voltage
// - Op-amp mode converts second extended pin
module adcc_device #(
  parameter int CYC_SH_8 = adcc_pkg::CYC_SH_8,
  parameter int CYC_SH_10 = adcc_pkg::CYC_SH_10,
  parameter int CYC_NOSH_8 = adcc_pkg::CYC_NOSH_8,
  parameter int CYC_NOSH_10 = adcc_pkg::CYC_NOSH_10
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Link to the controller end
  adcc_if.dev link
);
  // ****************************************
  // Checks and types
  // ****************************************
  if (CYC_SH_8 < 2 || CYC_SH_10 < 2 || CYC_NOSH_8 < 2 ||
      CYC_NOSH_10 < 2 || CYC_SH_8 > 63 || CYC_SH_10 > 63 ||
      CYC_NOSH_8 > 63 || CYC_NOSH_10 > 63)
  begin : g_bad
    $error("conversion counts must lie in 2..63");
  end

  typedef struct packed {
    adcc_pkg::adcc_state_t st;
    logic [5:0] cnt;
    logic [5:0] last;
    logic [2:0] dest;
    logic res10;
    logic start_q;
    logic trig_q;
    logic [7:0][9:0] res;
    logic busy;
    logic done;
    logic dma_req;
    logic [15:0] first;
    logic [15:0] rd;
    logic [3:0] in_sel;
    logic ex0_out;
    logic ex0_in;
    logic ex1_in;
  } adcc_dev_t;

  adcc_dev_t s;
  adcc_dev_t n;

  // ****************************************
  // Helpers
  // ****************************************
  // Last count of a conversion for the current speed and resolution
  function automatic logic [5:0] last_count(input logic sample_hold_enable,
                                            input logic r10);
    int c;
    begin
      if (sample_hold_enable)
        c = r10 ? CYC_SH_10 : CYC_SH_8;
      else
        c = r10 ? CYC_NOSH_10 : CYC_NOSH_8;
      last_count = 6'(c - 1);
    end
  endfunction

  // Pin to convert for a given extended-input setting
  function automatic logic [3:0] pick_src(input logic [1:0] ext,
                                          input logic [2:0] ch);
    begin
      unique case (ext)
        adcc_pkg::EXT_NONE: pick_src = {1'b0, ch};
        adcc_pkg::EXT_FIRST: pick_src = adcc_pkg::SRC_EXT0;
        adcc_pkg::EXT_SECOND, adcc_pkg::EXT_OPAMP:
          pick_src = adcc_pkg::SRC_EXT1;
      endcase
    end
  endfunction

  // Result register that receives a conversion
  function automatic logic [2:0] pick_dest(input logic [1:0] ext,
                                           input logic [2:0] ch,
                                           input logic dma);
    begin
      // extended pins to first and second register
      unique case (ext)
        adcc_pkg::EXT_FIRST: pick_dest = 3'h0;
        adcc_pkg::EXT_SECOND: pick_dest = 3'h1;
        default: pick_dest = ch;
      endcase
      // DMA mode funnels into register zero
      if (dma)
        pick_dest = 3'h0;
    end
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  logic sw_go;
  logic ext_fall;
  logic hw_go;

  // One process works out the whole next state
  always_comb
  begin
    n = s;
    n.done = 1'b0;
    n.dma_req = 1'b0;
    n.start_q = link.start_bit;
    n.trig_q = link.ext_trig_pin;
    // software start on the rising start bit
    sw_go = !link.trig_type && link.start_bit && !s.start_q;
    // falling edge of the external pin
    ext_fall = s.trig_q && !link.ext_trig_pin;
    // hardware sources gated by the start bit
    hw_go = link.trig_type && link.start_bit &&
            (link.trig_src ? link.timer_trig : ext_fall);
    unique case (s.st)
      adcc_pkg::ST_IDLE:
      begin
        if (sw_go || hw_go)
        begin
          n.st = adcc_pkg::ST_CONV;
          n.cnt = 6'h00;
          n.busy = 1'b1;
          n.res10 = link.res_10;
          n.last = last_count(link.smp_en, link.res_10);
          n.dest = pick_dest(link.ext_field, link.channel_sel,
                             link.dma_en);
        end
      end
      adcc_pkg::ST_CONV:
      begin
        if (!link.start_bit)
        begin
          // Clearing the start bit halts; the result stays unwritten
          n.st = adcc_pkg::ST_IDLE;
          n.busy = 1'b0;
        end
        else if (hw_go)
          // abort and restart from the top
          n.cnt = 6'h00;
        else if (s.cnt == s.last)
        begin
          n.res[s.dest] = s.res10 ? link.analog_code :
                          {2'b00, link.analog_code[9:2]};
          n.done = 1'b1;
          n.dma_req = link.dma_en;
          n.cnt = 6'h00;
          if (!link.repeat_mode)
          begin
            n.st = adcc_pkg::ST_IDLE;
            n.busy = 1'b0;
          end
        end
        else
          n.cnt = s.cnt + 6'h01;
      end
    endcase
    // rd_data lags the array by one cycle; first_result follows it with no lag
    n.first = {6'h00, n.res[0]};
    n.rd = {6'h00, s.res[link.rd_index]};
    n.in_sel = pick_src(link.ext_field, link.channel_sel);
    n.ex0_in = link.ext_field == adcc_pkg::EXT_FIRST;
    n.ex1_in = link.ext_field[1];
    // main channel driven out of the first pin
    n.ex0_out = link.ext_field == adcc_pkg::EXT_OPAMP;
  end

  // ****************************************
  // State register
  // ****************************************
  // Synchronous reset; the trigger pin idles high
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.st <= adcc_pkg::ST_IDLE;
      s.trig_q <= 1'b1;
    end
    else
      s <= n;
  end

  // Outputs straight from the state flops
  assign link.busy = s.busy;
  assign link.conv_done = s.done;
  assign link.dma_req = s.dma_req;
  assign link.first_result = s.first;
  assign link.rd_data = s.rd;
  assign link.input_sel = s.in_sel;
  assign link.ext0_out_en = s.ex0_out;
  assign link.ext0_in_en = s.ex0_in;
  assign link.ext1_in_en = s.ex1_in;
endmodule
`default_nettype wire

// [adcc_ctl.sv]
/*
  Controller end: AXI4-Lite registers for software, trigger sources
  and the DMA capture of funnelled results.
  Assumes AXI4-Lite on mclk with 32-bit data.
*/
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module adcc_ctl #(
  parameter int AW = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // AXI4-Lite write
  input wire logic [AW-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read
  input wire logic [AW-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Link to the converter
  adcc_if.ctl link
);
  if (AW < 8)
  begin : g_bad
    $error("address width must be at least 8");
  end

  typedef struct packed {
    logic [14:0] ctrl;
    logic done;
    logic dmav;
    logic [15:0] dma_word;
    logic [2:0] idx;
    logic pin;
    logic pulse;
    logic [9:0] code;
    logic aw_have;
    logic w_have;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } adcc_ctl_t;

  adcc_ctl_t s;
  adcc_ctl_t n;
  logic [14:0] c;
  logic free;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    n = s;
    n.pulse = 1'b0;
    c = s.ctrl;
    free = !link.busy && !s.ctrl[adcc_pkg::B_START];
    // Completion sets the flag; a clear in the same cycle loses
    if (link.conv_done && !s.ctrl[adcc_pkg::B_REPEAT])
      n.ctrl[adcc_pkg::B_START] = 1'b0;
    if (link.dma_req)
    begin
      n.dma_word = s.ctrl[adcc_pkg::B_RES10] ? link.first_result :
                   {8'h00, link.first_result[7:0]};
      n.dmav = 1'b1;
    end
    // Write channel: address and data taken in either order
    if (s_awvalid && s.awready)
    begin
      n.aw_have = 1'b1;
      n.waddr = s_awaddr[7:0];
      n.awready = 1'b0;
    end
    if (s_wvalid && s.wready)
    begin
      n.w_have = 1'b1;
      n.wdata = s_wdata;
      n.wready = 1'b0;
    end
    if (s.aw_have && s.w_have && !s.bvalid)
    begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = adcc_pkg::RESP_OK;
      unique case (s.waddr)
        adcc_pkg::OFS_CTRL:
        begin
          if (s_wstrb[0] || s_wstrb[1])
          begin
            n.ctrl = s.wdata[14:0];
            if (!free)
              n.ctrl[adcc_pkg::B_SMP] = c[adcc_pkg::B_SMP];
          end
        end
        adcc_pkg::OFS_STATUS:
        begin
          if (s.wdata[adcc_pkg::B_DONE] && !link.conv_done)
            n.done = 1'b0;
          if (s.wdata[adcc_pkg::B_DMAV] && !link.dma_req)
            n.dmav = 1'b0;
        end
        adcc_pkg::OFS_RESULT: n.idx = s.wdata[2:0];
        adcc_pkg::OFS_TRIG:
        begin
          n.pulse = s.wdata[0];
          n.pin = s.wdata[adcc_pkg::B_EXTPIN];
        end
        adcc_pkg::OFS_ANALOG: n.code = s.wdata[9:0];
        default: n.bresp = adcc_pkg::RESP_ERR;
      endcase
    end
    if (s.bvalid && s_bready)
    begin
      n.bvalid = 1'b0;
      n.awready = 1'b1;
      n.wready = 1'b1;
    end
    if (link.conv_done)
      n.done = 1'b1;
    // Read channel: one outstanding read, answer in the next cycle
    if (s_arvalid && s.arready)
    begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = adcc_pkg::RESP_OK;
      n.rdata = 32'h0000_0000;
      unique case (s_araddr[7:0])
        adcc_pkg::OFS_CTRL: n.rdata = {17'h0_0000, s.ctrl};
        adcc_pkg::OFS_STATUS:
          n.rdata = {29'h0000_0000, s.dmav, s.done, link.busy};
        adcc_pkg::OFS_RESULT:
          if (!(link.dma_en && s.idx == 3'h0))
            n.rdata = {16'h0000, link.rd_data};
        adcc_pkg::OFS_DMA: n.rdata = {16'h0000, s.dma_word};
        adcc_pkg::OFS_TRIG:
          n.rdata = {30'h0000_0000, s.pin, 1'b0};
        adcc_pkg::OFS_ANALOG: n.rdata = {22'h00_0000, s.code};
        default: n.rresp = adcc_pkg::RESP_ERR;
      endcase
    end
    if (s.rvalid && s_rready)
    begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.ctrl <= adcc_pkg::CTRL_RST;
      s.pin <= 1'b1;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end
    else
      s <= n;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign s_awready = s.awready;
  assign s_wready = s.wready;
  assign s_bvalid = s.bvalid;
  assign s_bresp = s.bresp;
  assign s_arready = s.arready;
  assign s_rvalid = s.rvalid;
  assign s_rdata = s.rdata;
  assign s_rresp = s.rresp;
  assign link.start_bit = s.ctrl[adcc_pkg::B_START];
  // type bit selects the trigger path
  assign link.trig_type = s.ctrl[adcc_pkg::B_TRG_TYPE];
  assign link.trig_src = s.ctrl[adcc_pkg::B_TRG_SRC];
  assign link.res_10 = s.ctrl[adcc_pkg::B_RES10];
  assign link.smp_en = s.ctrl[adcc_pkg::B_SMP];
  assign link.dma_en = s.ctrl[adcc_pkg::B_DMA] | s.ctrl[adcc_pkg::B_MSS];
  // extended inputs only with group 00 and no sweep
  assign link.ext_field = (s.ctrl[adcc_pkg::B_PGRP +: 2] == 2'h0 &&
                          !s.ctrl[adcc_pkg::B_MSS]) ?
                          s.ctrl[adcc_pkg::B_EXT +: 2] : 2'h0;
  assign link.repeat_mode = s.ctrl[adcc_pkg::B_REPEAT];
  assign link.channel_sel = s.ctrl[adcc_pkg::B_CHAN +: 3];
  assign link.ext_trig_pin = s.pin;
  assign link.timer_trig = s.pulse;
  assign link.analog_code = s.code;
  assign link.rd_index = s.idx;
endmodule
`default_nettype wire

// [adcc_checker.sv]
/*
  Checker for the converter link: triggers, timing, DMA, pin decode.
  Assumes one clock and the link signals wired in as plain inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module adcc_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Controller side
  input wire logic start_bit,
  input wire logic trig_type,
  input wire logic trig_src,
  input wire logic res_10,
  input wire logic smp_en,
  input wire logic dma_en,
  input wire logic [1:0] ext_field,
  input wire logic ext_trig_pin,
  input wire logic timer_trig,
  input wire logic [9:0] analog_code,
  // Converter side
  input wire logic busy,
  input wire logic conv_done,
  input wire logic dma_req,
  input wire logic [15:0] first_result,
  input wire logic ext0_out_en,
  input wire logic ext0_in_en,
  input wire logic ext1_in_en
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ****************************************
  // Trigger tracking
  // ****************************************
  logic prev_start;
  logic prev_pin;
  logic [1:0] prev_ext;
  logic [7:0] cnt;
  logic [7:0] exp_len;
  logic trig_hw;
  logic trig_ev;
  // Only qualified triggers count, so stray edges stay visible
  assign trig_hw = trig_type && start_bit &&
    (trig_src ? timer_trig : (prev_pin && !ext_trig_pin));
  assign trig_ev = trig_hw || (!trig_type && start_bit && !prev_start);
  assign exp_len = res_10 ? 8'(adcc_pkg::CYC_SH_10) : 8'(adcc_pkg::CYC_SH_8);
  // Cycles since the last start; a result restarts it for repeat runs
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      prev_start <= 1'b0;
      prev_pin <= 1'b1;
      prev_ext <= 2'h0;
      cnt <= 8'h00;
    end
    else
    begin
      prev_start <= start_bit;
      prev_pin <= ext_trig_pin;
      prev_ext <= ext_field;
      if (trig_ev)
        cnt <= 8'h01;
      // A repeat run restarted one edge before its done pulse is seen
      else if (conv_done)
        cnt <= 8'h02;
      else if (cnt != 8'h00 && cnt != 8'hff)
        cnt <= cnt + 8'h01;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  sequence s_restart;
    (busy && !conv_done) [*8];
  endsequence
  property p_trig_busy;
    trig_ev |=> busy;
  endproperty
  property p_done_time;
    conv_done && smp_en |-> cnt == exp_len + 8'h01;
  endproperty
  property p_gated;
    trig_type && !start_bit && !busy |=> !busy;
  endproperty
  property p_retrig;
    busy && trig_hw |=> s_restart;
  endproperty
  property p_dma_req;
    conv_done |-> dma_req == dma_en;
  endproperty
  property p_req_done;
    dma_req |-> conv_done;
  endproperty
  property p_res10;
    conv_done && dma_en && res_10 && $stable(analog_code)
      |-> first_result == {6'h00, analog_code};
  endproperty
  property p_res8;
    conv_done && dma_en && !res_10 && $stable(analog_code)
      |-> first_result == {8'h00, analog_code[9:2]};
  endproperty
  property p_ext_pins;
    {ext0_out_en, ext0_in_en, ext1_in_en} ==
      {prev_ext == 2'h3, prev_ext == 2'h1, prev_ext[1]};
  endproperty
  property p_done_busy;
    conv_done |-> $past(busy);
  endproperty
  a_trig_busy: assert property (p_trig_busy)
    else $error("busy did not follow a start");
  a_done_time: assert property (p_done_time)
    else $error("conversion length wrong");
  a_gated: assert property (p_gated)
    else $error("conversion began without start bit");
  a_retrig: assert property (p_retrig)
    else $error("retrigger did not restart");
  a_dma_req: assert property (p_dma_req)
    else $error("dma request does not match mode");
  a_req_done: assert property (p_req_done)
    else $error("dma request without result");
  a_res10: assert property (p_res10)
    else $error("10-bit result misplaced");
  a_res8: assert property (p_res8)
    else $error("8-bit result misplaced");
  a_ext_pins: assert property (p_ext_pins)
    else $error("extended pin decode wrong");
  a_done_busy: assert property (p_done_busy)
    else $error("done without a conversion");
endmodule
`default_nettype wire

// [adc_conversion_control_tb.sv]
/*
  Bench: software drives the controller over AXI4-Lite, both ends
  meet on adcc_if and the checker watches the link.
  Assumes the converter end keeps its default counts.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_tb;
  localparam logic [1:0] OK = adcc_pkg::RESP_OK;
  localparam logic [1:0] NONE = adcc_pkg::EXT_NONE;
  logic mclk;
  logic rst_n;
  logic [7:0] s_awaddr;
  logic s_awvalid;
  logic s_awready;
  logic [31:0] s_wdata;
  logic [3:0] s_wstrb;
  logic s_wvalid;
  logic s_wready;
  logic [1:0] s_bresp;
  logic s_bvalid;
  logic s_bready;
  logic [7:0] s_araddr;
  logic s_arvalid;
  logic s_arready;
  logic [31:0] s_rdata;
  logic [1:0] s_rresp;
  logic s_rvalid;
  logic s_rready;
  int failures;
  int samples_checked;
  int run_len;
  adcc_if link ();
  adcc_device u_adcc_device (.mclk(mclk), .rst_n(rst_n), .link(link.dev));
  adcc_ctl u_adcc_ctl (.mclk(mclk), .rst_n(rst_n),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .link(link.ctl));
  adcc_checker u_adcc_checker (.mclk(mclk), .rst_n(rst_n),
    .start_bit(link.start_bit), .trig_type(link.trig_type),
    .trig_src(link.trig_src), .res_10(link.res_10),
    .smp_en(link.smp_en), .dma_en(link.dma_en),
    .ext_field(link.ext_field), .ext_trig_pin(link.ext_trig_pin),
    .timer_trig(link.timer_trig), .analog_code(link.analog_code),
    .busy(link.busy), .conv_done(link.conv_done),
    .dma_req(link.dma_req), .first_result(link.first_result),
    .ext0_out_en(link.ext0_out_en), .ext0_in_en(link.ext0_in_en),
    .ext1_in_en(link.ext1_in_en));
  // Clock at 10 MHz
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Busy cycles seen so far; zero while idle
  always @(posedge mclk)
    run_len <= (link.busy === 1'b1) ? run_len + 1 : 0;
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic close_out;
    if (failures == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check_eq(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  // Address and data offered together, each dropped when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] exp);
    @(posedge mclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_awready === 1'b1)
        s_awvalid <= 1'b0;
      if (s_wready === 1'b1)
        s_wvalid <= 1'b0;
    end
    while (s_bvalid !== 1'b1);
    s_bready <= 1'b0;
    check_eq(32'(s_bresp), 32'(exp));
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
    input logic [1:0] exp);
    @(posedge mclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_arready === 1'b1)
        s_arvalid <= 1'b0;
    end
    while (s_rvalid !== 1'b1);
    s_rready <= 1'b0;
    d = s_rdata;
    check_eq(32'(s_rresp), 32'(exp));
  endtask
  function automatic logic [31:0] ctrl_word(input logic [2:0] trigger_type_select,
    input logic res, input logic dma, input logic [1:0] ext,
    input logic [2:0] ch);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[2:0] = trigger_type_select;
    w[adcc_pkg::B_RES10] = res;
    w[adcc_pkg::B_SMP] = 1'b1;
    w[adcc_pkg::B_DMA] = dma;
    w[adcc_pkg::B_EXT +: 2] = ext;
    w[adcc_pkg::B_CHAN +: 3] = ch;
    return w;
  endfunction
  task automatic cfg(input logic [31:0] w);
    axi_write(adcc_pkg::OFS_CTRL, w & 32'hffff_fffe, OK);
    axi_write(adcc_pkg::OFS_CTRL, w, OK);
  endtask
  task automatic wait_done;
    do
      @(posedge mclk);
    while (link.conv_done !== 1'b1);
  endtask
  task automatic read_result(input logic [2:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    axi_write(adcc_pkg::OFS_RESULT, 32'(idx), OK);
    axi_read(adcc_pkg::OFS_RESULT, d, OK);
    check_eq(d, exp);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    logic [31:0] d;
    axi_read(adcc_pkg::OFS_CTRL, d, OK);
    check_eq(d, 32'(adcc_pkg::CTRL_RST));
    axi_read(8'h40, d, adcc_pkg::RESP_ERR);
    check_eq(d, 32'h0000_0000);
    axi_write(8'h44, 32'h0000_ffff, adcc_pkg::RESP_ERR);
  endtask
  task automatic t_resolution;
    logic [31:0] d;
    for (int r = 0; r < 2; r++)
    begin
      axi_write(adcc_pkg::OFS_ANALOG, 32'h0000_02b7, OK);
      cfg(ctrl_word(3'h1, r[0], 1'b0, NONE, 3'h4));
      wait_done();
      check_eq(run_len, r ? adcc_pkg::CYC_SH_10 : adcc_pkg::CYC_SH_8);
      read_result(3'h4, r ? 32'h0000_02b7 : 32'h0000_00ad);
      axi_read(adcc_pkg::OFS_STATUS, d, OK);
      check_eq(32'(d[adcc_pkg::B_DONE]), 32'h0000_0001);
      axi_write(adcc_pkg::OFS_STATUS, 32'h0000_0002, OK);
    end
  endtask
  // Every extended-field code, result index by code
  task automatic t_ext_fields;
    for (int e = 0; e < 4; e++)
    begin
      axi_write(adcc_pkg::OFS_ANALOG, 32'h0000_0150 + e, OK);
      cfg(ctrl_word(3'h1, 1'b1, 1'b0, e[1:0], 3'h5));
      check_eq({link.ext0_out_en, link.ext0_in_en, link.ext1_in_en},
        {e == 3, e == 1, e[1]});
      check_eq(32'(link.input_sel),
        e == 0 ? 32'h0000_0005 : e == 1 ? 32'h0000_0008 : 32'h0000_0009);
      wait_done();
      read_result(e == 1 ? 3'h0 : e == 2 ? 3'h1 : 3'h5, 32'h0000_0150 + e);
    end
  endtask
  task automatic t_ext_trig;
    logic [31:0] d;
    axi_write(adcc_pkg::OFS_ANALOG, 32'h0000_03c9, OK);
    axi_write(adcc_pkg::OFS_CTRL, ctrl_word(3'h2, 1'b1, 1'b1, NONE, 3'h0), OK);
    // Falling edge while start is clear must be ignored
    axi_write(adcc_pkg::OFS_TRIG, 32'h0000_0000, OK);
    axi_read(adcc_pkg::OFS_STATUS, d, OK);
    check_eq(32'(d[0]), 32'h0000_0000);
    axi_write(adcc_pkg::OFS_TRIG, 32'h0000_0002, OK);
    axi_write(adcc_pkg::OFS_CTRL, ctrl_word(3'h3, 1'b1, 1'b1, NONE, 3'h0), OK);
    axi_write(adcc_pkg::OFS_TRIG, 32'h0000_0000, OK);
    wait_done();
    check_eq(run_len, adcc_pkg::CYC_SH_10);
    axi_read(adcc_pkg::OFS_DMA, d, OK);
    check_eq(d, 32'h0000_03c9);
    axi_write(adcc_pkg::OFS_TRIG, 32'h0000_0002, OK);
  endtask
  // Second timer pulse lands mid-conversion and restarts it
  task automatic t_hw_retrig;
    logic [31:0] d;
    axi_write(adcc_pkg::OFS_ANALOG, 32'h0000_00f3, OK);
    cfg(ctrl_word(3'h7, 1'b0, 1'b1, NONE, 3'h2));
    axi_write(adcc_pkg::OFS_TRIG, 32'h0000_0003, OK);
    axi_write(adcc_pkg::OFS_TRIG, 32'h0000_0003, OK);
    wait_done();
    check_eq(32'(run_len > adcc_pkg::CYC_SH_8), 32'h0000_0001);
    axi_read(adcc_pkg::OFS_STATUS, d, OK);
    check_eq(32'(d[adcc_pkg::B_DMAV]), 32'h0000_0001);
    axi_read(adcc_pkg::OFS_DMA, d, OK);
    check_eq(d, 32'h0000_003c);
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial
  begin
    failures = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    s_awaddr = 8'h00;
    s_awvalid = 1'b0;
    s_wdata = 32'h0000_0000;
    s_wstrb = 4'hf;
    s_wvalid = 1'b0;
    s_bready = 1'b0;
    s_araddr = 8'h00;
    s_arvalid = 1'b0;
    s_rready = 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_resolution();
    t_ext_fields();
    t_ext_trig();
    t_hw_retrig();
    close_out();
  end
  // About forty times the expected run of some five hundred cycles
  initial
  begin
    #2000000;
    failures = failures + 1;
    close_out();
  end
endmodule
`default_nettype wire
